/* hdl/swx_defs.vh */
// Constants for the status word and exception entry sequencer.
// Assumes inclusion by bare name from the design files.
`ifndef SWX_DEFS_VH
`define SWX_DEFS_VH
// ==========================================================
// Status word fields
`define SWX_Q_BIT 27
`define SWX_I_BIT 7
`define SWX_F_BIT 6
`define SWX_T_BIT 5
`define SWX_M_HI 4
`define SWX_CTRL_HI 7
// ==========================================================
// Mode encodings
`define SWX_MODE_USR 5'h10
`define SWX_MODE_FIQ 5'h11
`define SWX_MODE_IRQ 5'h12
`define SWX_MODE_SVC 5'h13
`define SWX_MODE_ABT 5'h17
`define SWX_MODE_UND 5'h1b
`define SWX_MODE_SYS 5'h1f
// ==========================================================
// Exception kinds
`define SWX_EXC_NONE 3'h0
`define SWX_EXC_DATA_ABORT 3'h1
`define SWX_EXC_FIQ 3'h2
`define SWX_EXC_IRQ 3'h3
`define SWX_EXC_PREF_ABORT 3'h4
`define SWX_EXC_BREAK 3'h5
`define SWX_EXC_UND 3'h6
`define SWX_EXC_TRAP 3'h7
// ==========================================================
// Link offsets and saved word bank indices
`define SWX_OFS_2 32'h0000_0002
`define SWX_OFS_4 32'h0000_0004
`define SWX_OFS_8 32'h0000_0008
`define SWX_BANK_FIQ 3'h0
`define SWX_BANK_IRQ 3'h1
`define SWX_BANK_SVC 3'h2
`define SWX_BANK_ABT 3'h3
`define SWX_BANK_UND 3'h4
`define SWX_BANK_NONE 3'h7
// ==========================================================
// Sequencer states
`define SWX_ST_RUN 2'h0
`define SWX_ST_LINK 2'h1
`define SWX_ST_SAVE 2'h2
`define SWX_ST_VECT 2'h3
`endif

/* hdl/swx_bank_map.v */
// Maps a mode field to its banked register group and saved word slot.
// Assumes the mode field comes from the current status word or from the mode being entered.
`timescale 1ns/1ps
`include "swx_defs.vh"
module swx_bank_map (
  input wire [4:0] mode_i,
  output reg [2:0] bank_o,
  output reg fiq_bank_o,
  output reg priv_o,
  output reg valid_o
);
  // ==========================================================
  // Decode
  always @* begin
    bank_o = `SWX_BANK_NONE;
    fiq_bank_o = 1'b0;
    priv_o = 1'b1;
    valid_o = 1'b1;
    case (mode_i)
      `SWX_MODE_USR: begin
        priv_o = 1'b0;
      end
      `SWX_MODE_FIQ: begin
        bank_o = `SWX_BANK_FIQ;
        fiq_bank_o = 1'b1;
      end
      `SWX_MODE_IRQ: bank_o = `SWX_BANK_IRQ;
      `SWX_MODE_SVC: bank_o = `SWX_BANK_SVC;
      `SWX_MODE_ABT: bank_o = `SWX_BANK_ABT;
      `SWX_MODE_UND: bank_o = `SWX_BANK_UND;
      `SWX_MODE_SYS: bank_o = `SWX_BANK_NONE;
      default: begin
        // An illegal mode is flagged only; reset or an exception entry restores a valid mode.
        valid_o = 1'b0;
        priv_o = 1'b0;
      end
    endcase
  end
endmodule

/* hdl/swx_status_exc.v */
// Status word holder and exception entry sequencer for a processor core.
// Assumes the pipeline marks instruction boundaries and presents PC values.
// Operation
// - Saturating add, subtract or signed MAC overflow sets the sticky flag.
// - Sticky flag stays set until a status write to the current word or a flag-setting return clears it.
// - Sticky flag is not offered to condition evaluation.
// - Low eight bits are masks, state bit and five-bit mode.
// - Entries update control bits; software writes them only when privileged.
// - Normal interrupt mask set blocks the normal request.
// - Fast interrupt mask set blocks the fast request.
// - State bit is one in compressed set and drives the indicator output.
// - Mode field decodes into seven valid modes.
// - Illegal mode need not recover; only reset restores operation. Here an exception entry also forces a valid mode.
// - Registers are banked per mode; exception modes own a saved word.
// - Simultaneous exceptions are taken one at a time by fixed priority.
// - Software and undefined traps link PC+4 native or PC+2 compressed.
// - Prefetch abort, breakpoint and interrupts link PC+4.
// - Data abort links PC+8.
// - Reset leaves the supervisor link register undefined.
// - Entry saves link, copies status, forces mode, then vectors.
// - Entry may set interrupt masks to stop uncontrolled nesting.
// - Every exception enters in native state; state bit clears at vector.
// - Fast entry sets both masks; others set the normal mask.
// - Flag-setting return to PC copies saved word back to current.
// - Reset release forces supervisor mode, both masks, native state.
`timescale 1ns/1ps
`include "swx_defs.vh"
module swx_status_exc #(
  parameter WORD_W = 32
) (
  input wire CLK_I,
  input wire RST_I,
  input wire BOUNDARY_I,
  input wire [WORD_W-1:0] PC_I,
  input wire FAST_REQUEST_N_I,
  input wire NORMAL_REQUEST_N_I,
  input wire DATA_ABORT_I,
  input wire PREFETCH_ABORT_I,
  input wire BREAKPOINT_INSTR_I,
  input wire UNDEFINED_INSTR_TRAP_I,
  input wire SOFTWARE_TRAP_I,
  input wire SAT_OVERFLOW_I,
  input wire STATUS_WRITE_INSTR_I,
  input wire STATUS_WRITE_SAVED_I,
  input wire [3:0] STATUS_WRITE_MASK_I,
  input wire [WORD_W-1:0] STATUS_WRITE_DATA_I,
  input wire FLAG_RETURN_I,
  input wire STATE_SET_I,
  input wire STATE_VALUE_I,
  output wire [WORD_W-1:0] CURRENT_STATUS_WORD_O,
  output wire [WORD_W-1:0] SAVED_STATUS_WORD_O,
  output wire [3:0] COND_FLAGS_O,
  output wire STATE_INDICATOR_OUT_O,
  output wire [2:0] REG_BANK_O,
  output wire FIQ_BANK_O,
  output wire MODE_VALID_O,
  output wire ENTRY_BUSY_O,
  output reg LINK_WE_O,
  output reg [2:0] LINK_BANK_O,
  output reg [WORD_W-1:0] LINK_DATA_O,
  output reg VECTOR_FETCH_O,
  output reg [2:0] VECTOR_KIND_O
);
  // ==========================================================
  // State
  reg [WORD_W-1:0] cur_q;
  reg [WORD_W-1:0] cur_d;
  reg [WORD_W-1:0] saved_q [0:4];
  reg [1:0] st_q;
  reg [1:0] st_d;
  reg [2:0] exc_q;
  reg [2:0] exc_d;
  reg [WORD_W-1:0] pc_q;
  reg fiq_n_q;
  reg irq_n_q;
  reg [2:0] exc_pick;
  reg [4:0] new_mode;
  reg [2:0] new_bank;
  reg [WORD_W-1:0] link_ofs;
  wire [2:0] bank;
  wire fiq_bank;
  wire priv;
  wire mode_valid;
  wire [2:0] save_bank;
  wire has_saved;
  wire fiq_take;
  wire irq_take;
  integer i;

  swx_bank_map u_map (
    .mode_i(cur_q[`SWX_M_HI:0]),
    .bank_o(bank),
    .fiq_bank_o(fiq_bank),
    .priv_o(priv),
    .valid_o(mode_valid)
  );

  // Second decoder names the saved word slot of the mode being entered.
  swx_bank_map u_new_map (
    .mode_i(new_mode),
    .bank_o(save_bank),
    .fiq_bank_o(),
    .priv_o(),
    .valid_o()
  );

  assign has_saved = (bank != `SWX_BANK_NONE);
  assign CURRENT_STATUS_WORD_O = cur_q;
  assign SAVED_STATUS_WORD_O = has_saved ? saved_q[bank] : {WORD_W{1'b0}};
  // Condition flags exclude the sticky bit so it can never gate execution.
  assign COND_FLAGS_O = cur_q[WORD_W-1:WORD_W-4];
  assign STATE_INDICATOR_OUT_O = cur_q[`SWX_T_BIT];
  assign REG_BANK_O = bank;
  assign FIQ_BANK_O = fiq_bank;
  assign MODE_VALID_O = mode_valid;
  assign ENTRY_BUSY_O = (st_q != `SWX_ST_RUN);

  // ==========================================================
  // Request registers
  always @(posedge CLK_I) begin
    if (RST_I) begin
      // Requests read inactive through reset, so release raises no false entry.
      fiq_n_q <= 1'b1;
      irq_n_q <= 1'b1;
    end else begin
      fiq_n_q <= FAST_REQUEST_N_I;
      irq_n_q <= NORMAL_REQUEST_N_I;
    end
  end

  assign fiq_take = ~fiq_n_q & ~cur_q[`SWX_F_BIT];
  assign irq_take = ~irq_n_q & ~cur_q[`SWX_I_BIT];

  // ==========================================================
  // Priority pick, one exception per boundary
  // The order is fixed, so sources pending together never race for entry.
  always @* begin
    exc_pick = `SWX_EXC_NONE;
    if (DATA_ABORT_I) begin
      exc_pick = `SWX_EXC_DATA_ABORT;
    end else if (fiq_take) begin
      exc_pick = `SWX_EXC_FIQ;
    end else if (irq_take) begin
      exc_pick = `SWX_EXC_IRQ;
    end else if (PREFETCH_ABORT_I) begin
      exc_pick = `SWX_EXC_PREF_ABORT;
    end else if (BREAKPOINT_INSTR_I) begin
      exc_pick = `SWX_EXC_BREAK;
    end else if (UNDEFINED_INSTR_TRAP_I) begin
      exc_pick = `SWX_EXC_UND;
    end else if (SOFTWARE_TRAP_I) begin
      exc_pick = `SWX_EXC_TRAP;
    end
  end

  // ==========================================================
  // Target mode and link offset of the exception in progress
  // Breakpoints are handled as prefetch aborts and share the abort mode.
  always @* begin
    case (exc_q)
      `SWX_EXC_FIQ: new_mode = `SWX_MODE_FIQ;
      `SWX_EXC_IRQ: new_mode = `SWX_MODE_IRQ;
      `SWX_EXC_DATA_ABORT: new_mode = `SWX_MODE_ABT;
      `SWX_EXC_PREF_ABORT: new_mode = `SWX_MODE_ABT;
      `SWX_EXC_BREAK: new_mode = `SWX_MODE_ABT;
      `SWX_EXC_UND: new_mode = `SWX_MODE_UND;
      `SWX_EXC_TRAP: new_mode = `SWX_MODE_SVC;
      default: new_mode = `SWX_MODE_SVC;
    endcase
    new_bank = save_bank;
    case (exc_q)
      `SWX_EXC_DATA_ABORT: link_ofs = `SWX_OFS_8;
      `SWX_EXC_UND, `SWX_EXC_TRAP: begin
        link_ofs = cur_q[`SWX_T_BIT] ? `SWX_OFS_2 : `SWX_OFS_4;
      end
      default: link_ofs = `SWX_OFS_4;
    endcase
  end

  // ==========================================================
  // Entry sequencer
  // One state per step keeps link, save and vector writes in their fixed order.
  always @* begin
    st_d = st_q;
    exc_d = exc_q;
    case (st_q)
      `SWX_ST_RUN: begin
        if (BOUNDARY_I && exc_pick != `SWX_EXC_NONE) begin
          st_d = `SWX_ST_LINK;
          exc_d = exc_pick;
        end
      end
      `SWX_ST_LINK: st_d = `SWX_ST_SAVE;
      `SWX_ST_SAVE: st_d = `SWX_ST_VECT;
      `SWX_ST_VECT: begin
        st_d = `SWX_ST_RUN;
        exc_d = `SWX_EXC_NONE;
      end
      default: st_d = `SWX_ST_RUN;
    endcase
  end

  // ==========================================================
  // Current status word update
  always @* begin
    cur_d = cur_q;
    // Status writes and returns are refused while an entry is in flight.
    if (st_q == `SWX_ST_RUN) begin
      if (FLAG_RETURN_I && has_saved) begin
        cur_d = saved_q[bank];
      end else if (STATUS_WRITE_INSTR_I && !STATUS_WRITE_SAVED_I) begin
        // Reserved bits ride along with the fields and steer nothing.
        if (STATUS_WRITE_MASK_I[3]) begin
          cur_d[WORD_W-1:24] = STATUS_WRITE_DATA_I[WORD_W-1:24];
        end
        if (STATUS_WRITE_MASK_I[2]) begin
          cur_d[23:16] = STATUS_WRITE_DATA_I[23:16];
        end
        if (STATUS_WRITE_MASK_I[1]) begin
          cur_d[15:8] = STATUS_WRITE_DATA_I[15:8];
        end
        // Control byte writes from an unprivileged mode are dropped, not faulted.
        if (STATUS_WRITE_MASK_I[0] && priv) begin
          cur_d[`SWX_CTRL_HI:0] = STATUS_WRITE_DATA_I[`SWX_CTRL_HI:0];
        end
      end else if (STATE_SET_I) begin
        cur_d[`SWX_T_BIT] = STATE_VALUE_I;
      end
    end else if (st_q == `SWX_ST_SAVE) begin
      cur_d[`SWX_M_HI:0] = new_mode;
      cur_d[`SWX_I_BIT] = 1'b1;
      if (exc_q == `SWX_EXC_FIQ) begin
        cur_d[`SWX_F_BIT] = 1'b1;
      end
    end else if (st_q == `SWX_ST_VECT) begin
      cur_d[`SWX_T_BIT] = 1'b0;
    end
    // Overflow lands in every state and wins over a clear, so no event is lost.
    if (SAT_OVERFLOW_I) begin
      cur_d[`SWX_Q_BIT] = 1'b1;
    end
  end

  always @(posedge CLK_I) begin
    if (RST_I) begin
      cur_q <= {WORD_W{1'b0}};
      cur_q[`SWX_M_HI:0] <= `SWX_MODE_SVC;
      cur_q[`SWX_I_BIT] <= 1'b1;
      cur_q[`SWX_F_BIT] <= 1'b1;
      st_q <= `SWX_ST_RUN;
      exc_q <= `SWX_EXC_NONE;
      pc_q <= {WORD_W{1'b0}};
    end else begin
      cur_q <= cur_d;
      st_q <= st_d;
      exc_q <= exc_d;
      if (st_q == `SWX_ST_RUN) begin
        pc_q <= PC_I;
      end
    end
  end

  // ==========================================================
  // Saved status words; not reset, contents undefined until written
  always @(posedge CLK_I) begin
    if (st_q == `SWX_ST_SAVE) begin
      saved_q[new_bank] <= cur_q;
    end else if (st_q == `SWX_ST_RUN && STATUS_WRITE_INSTR_I && STATUS_WRITE_SAVED_I
                 && has_saved) begin
      for (i = 0; i < 4; i = i + 1) begin
        if (STATUS_WRITE_MASK_I[i]) begin
          saved_q[bank][i*8 +: 8] <= STATUS_WRITE_DATA_I[i*8 +: 8];
        end
      end
    end
  end

  // ==========================================================
  // Link write and vector fetch strobes
  // Link data holds between writes; only the strobe says when it is valid.
  always @(posedge CLK_I) begin
    if (RST_I) begin
      // No link write at reset, so the supervisor link keeps no value.
      LINK_WE_O <= 1'b0;
      LINK_BANK_O <= `SWX_BANK_NONE;
      LINK_DATA_O <= {WORD_W{1'b0}};
      VECTOR_FETCH_O <= 1'b1;
      VECTOR_KIND_O <= `SWX_EXC_NONE;
    end else begin
      LINK_WE_O <= (st_q == `SWX_ST_LINK);
      LINK_BANK_O <= new_bank;
      if (st_q == `SWX_ST_LINK) begin
        LINK_DATA_O <= pc_q + link_ofs;
      end
      VECTOR_FETCH_O <= (st_q == `SWX_ST_VECT);
      VECTOR_KIND_O <= exc_q;
    end
  end
endmodule

/* testbench/swx_irq_src.sv */
// Interrupt source model driving the two active-low request lines.
// Assumes the bench commands each request as an active-high level.
`timescale 1ns/1ps
module swx_irq_src (
  input wire clk_i,
  input wire fast_req_i,
  input wire normal_req_i,
  output logic fast_request_n_o,
  output logic normal_request_n_o
);
  // Both lines idle high so nothing is requested until commanded.
  initial begin
    fast_request_n_o = 1'h1;
    normal_request_n_o = 1'h1;
  end
  always @(posedge clk_i) begin
    fast_request_n_o <= #1 !fast_req_i;
    normal_request_n_o <= #1 !normal_req_i;
  end
endmodule

/* testbench/swx_status_exc_assertions.sv */
// Port checker for the status word and exception entry sequencer.
// Assumes a single clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
module swx_status_exc_checker #(
  parameter WORD_W = 32
) (
  input wire CLK_I,
  input wire RST_I,
  input wire BOUNDARY_I,
  input wire SAT_OVERFLOW_I,
  input wire STATUS_WRITE_INSTR_I,
  input wire STATUS_WRITE_SAVED_I,
  input wire FLAG_RETURN_I,
  input wire [WORD_W-1:0] CURRENT_STATUS_WORD_O,
  input wire [WORD_W-1:0] SAVED_STATUS_WORD_O,
  input wire STATE_INDICATOR_OUT_O,
  input wire [2:0] REG_BANK_O,
  input wire FIQ_BANK_O,
  input wire MODE_VALID_O,
  input wire ENTRY_BUSY_O,
  input wire LINK_WE_O,
  input wire [2:0] LINK_BANK_O,
  input wire VECTOR_FETCH_O
);
  wire [4:0] mode = CURRENT_STATUS_WORD_O[4:0];
  default clocking @(posedge CLK_I);
  endclocking
  default disable iff (RST_I);
  // =====
  // Entry sequence
  a_link_after_start: assert property ($rose(ENTRY_BUSY_O) |=> LINK_WE_O)
    else $error("link write missing after entry start");
  a_vector_after_link: assert property (LINK_WE_O |-> ##2 VECTOR_FETCH_O)
    else $error("vector fetch not two cycles after link write");
  a_native_at_vector: assert property (VECTOR_FETCH_O |-> !CURRENT_STATUS_WORD_O[5])
    else $error("state bit set at vector fetch");
  a_fast_masks: assert property (
    LINK_WE_O && LINK_BANK_O == 3'h0 |=> CURRENT_STATUS_WORD_O[7:6] == 2'h3 && mode == 5'h11)
    else $error("fast entry without both masks");
  a_normal_mask: assert property (LINK_WE_O |=> CURRENT_STATUS_WORD_O[7])
    else $error("entry left normal mask clear");
  // =====
  // Status word
  a_indicator_tracks: assert property (STATE_INDICATOR_OUT_O == CURRENT_STATUS_WORD_O[5])
    else $error("indicator differs from state bit");
  a_sat_sets: assert property (
    SAT_OVERFLOW_I && !FLAG_RETURN_I |=> CURRENT_STATUS_WORD_O[27])
    else $error("overflow did not set sticky flag");
  a_sticky_holds: assert property (
    CURRENT_STATUS_WORD_O[27] && !STATUS_WRITE_INSTR_I && !FLAG_RETURN_I |=>
    CURRENT_STATUS_WORD_O[27])
    else $error("sticky flag dropped without a write");
  a_user_ctrl_locked: assert property (
    mode == 5'h10 && STATUS_WRITE_INSTR_I && !STATUS_WRITE_SAVED_I && !ENTRY_BUSY_O &&
    !BOUNDARY_I |=> $stable(CURRENT_STATUS_WORD_O[7:0]))
    else $error("user write changed control bits");
  a_mode_decode: assert property (
    MODE_VALID_O == (mode inside {5'h10, 5'h11, 5'h12, 5'h13, 5'h17, 5'h1b, 5'h1f}))
    else $error("mode validity wrong");
  a_bank_decode: assert property (
    MODE_VALID_O |-> FIQ_BANK_O == (mode == 5'h11) &&
    (REG_BANK_O == 3'h7) == (mode == 5'h10 || mode == 5'h1f))
    else $error("bank selection wrong");
  a_no_saved_word: assert property (REG_BANK_O == 3'h7 |-> SAVED_STATUS_WORD_O == '0)
    else $error("saved word shown in mode without one");
endmodule
bind swx_status_exc swx_status_exc_checker #(.WORD_W(WORD_W)) chk_u (
  .CLK_I(CLK_I), .RST_I(RST_I), .BOUNDARY_I(BOUNDARY_I), .SAT_OVERFLOW_I(SAT_OVERFLOW_I),
  .STATUS_WRITE_INSTR_I(STATUS_WRITE_INSTR_I), .STATUS_WRITE_SAVED_I(STATUS_WRITE_SAVED_I),
  .FLAG_RETURN_I(FLAG_RETURN_I), .CURRENT_STATUS_WORD_O(CURRENT_STATUS_WORD_O),
  .SAVED_STATUS_WORD_O(SAVED_STATUS_WORD_O), .STATE_INDICATOR_OUT_O(STATE_INDICATOR_OUT_O),
  .REG_BANK_O(REG_BANK_O), .FIQ_BANK_O(FIQ_BANK_O), .MODE_VALID_O(MODE_VALID_O),
  .ENTRY_BUSY_O(ENTRY_BUSY_O), .LINK_WE_O(LINK_WE_O), .LINK_BANK_O(LINK_BANK_O),
  .VECTOR_FETCH_O(VECTOR_FETCH_O)
);

/* testbench/testbench.sv */
// Self-checking bench for the status word and exception entry sequencer.
// Assumes the design, the request model and the checker are compiled first.
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic [2:0] k;
    logic t;
    logic [15:0] pc;
    logic [15:0] ln;
    logic [2:0] bk;
    logic [4:0] md;
  } swx_row_t;
  logic clk = 1'h0, rst = 1'h1, bnd = 1'h0, sat = 1'h0, fret = 1'h0, fq = 1'h0, nq = 1'h0;
  logic swr = 1'h0, swr_sv = 1'h0, sset = 1'h0, sval = 1'h0, fqn, nqn, got;
  logic [3:0] swr_mk = 4'h0;
  logic [6:0] src = 7'h00;
  logic [31:0] pc = 32'h0, swr_d = 32'h0, cur, sav, ldata, ln;
  logic [3:0] cond;
  logic [2:0] rbank, lbank, vk, bk, kd;
  logic ind, fbank, mvalid, busy, lwe, vf;
  integer errors = 0, compares = 0, i;
  swx_row_t rows [0:9] = '{'{3'h1, 1'h0, 16'h0100, 16'h0108, 3'h3, 5'h17},
    '{3'h1, 1'h1, 16'h0104, 16'h010c, 3'h3, 5'h17}, '{3'h2, 1'h1, 16'h0200, 16'h0204, 3'h0, 5'h11},
    '{3'h3, 1'h0, 16'h0300, 16'h0304, 3'h1, 5'h12}, '{3'h4, 1'h1, 16'h0400, 16'h0404, 3'h3, 5'h17},
    '{3'h5, 1'h0, 16'h0500, 16'h0504, 3'h3, 5'h17}, '{3'h6, 1'h0, 16'h0600, 16'h0604, 3'h4, 5'h1b},
    '{3'h6, 1'h1, 16'h0602, 16'h0604, 3'h4, 5'h1b}, '{3'h7, 1'h1, 16'h0700, 16'h0702, 3'h2, 5'h13},
    '{3'h7, 1'h0, 16'h0700, 16'h0704, 3'h2, 5'h13}};
  swx_irq_src src_u (.clk_i(clk), .fast_req_i(fq), .normal_req_i(nq), .fast_request_n_o(fqn),
    .normal_request_n_o(nqn));
  swx_status_exc dut_u (.CLK_I(clk), .RST_I(rst), .BOUNDARY_I(bnd), .PC_I(pc),
    .FAST_REQUEST_N_I(fqn), .NORMAL_REQUEST_N_I(nqn), .DATA_ABORT_I(src[0]),
    .PREFETCH_ABORT_I(src[3]), .BREAKPOINT_INSTR_I(src[4]), .UNDEFINED_INSTR_TRAP_I(src[5]),
    .SOFTWARE_TRAP_I(src[6]), .SAT_OVERFLOW_I(sat), .STATUS_WRITE_INSTR_I(swr),
    .STATUS_WRITE_SAVED_I(swr_sv), .STATUS_WRITE_MASK_I(swr_mk), .STATUS_WRITE_DATA_I(swr_d),
    .FLAG_RETURN_I(fret), .STATE_SET_I(sset), .STATE_VALUE_I(sval),
    .CURRENT_STATUS_WORD_O(cur), .SAVED_STATUS_WORD_O(sav), .COND_FLAGS_O(cond),
    .STATE_INDICATOR_OUT_O(ind), .REG_BANK_O(rbank), .FIQ_BANK_O(fbank), .MODE_VALID_O(mvalid),
    .ENTRY_BUSY_O(busy), .LINK_WE_O(lwe), .LINK_BANK_O(lbank), .LINK_DATA_O(ldata),
    .VECTOR_FETCH_O(vf), .VECTOR_KIND_O(vk));
  initial begin
    forever #2 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input integer n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic report_and_stop;
    if (errors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic do_reset;
    rst = 1'h1;
    tick(10);
    rst = 1'h0;
    chk(vf, 1'h1);
    chk(vk, 3'h0);
    chk(cur, 32'h0000_00d3);
    tick(1);
    chk(vf, 1'h0);
    chk(lwe, 1'h0);
  endtask
  task automatic wr(input logic sv, input logic [3:0] mk, input logic [31:0] d);
    {swr, swr_sv, swr_mk, swr_d} = {1'h1, sv, mk, d};
    tick(1);
    swr = 1'h0;
    tick(1);
  endtask
  task automatic enter(input logic [6:0] s, input logic [31:0] p);
    integer n;
    {ln, bk, kd} = 'x;
    // Requests lead the boundary by three edges since the model and the design each register them once.
    {fq, nq} = {s[1], s[2]};
    tick(3);
    {src, bnd, pc} = {s, 1'h1, p};
    tick(1);
    {src, bnd} = 8'h00;
    got = 1'h0;
    for (n = 0; n < 12 && !got; n++) begin
      if (lwe === 1'h1) begin
        ln = ldata;
        bk = lbank;
      end
      got = (vf === 1'h1);
      kd = vk;
      if (!got) tick(1);
    end
    {fq, nq} = 2'h0;
  endtask
  initial begin
    #100000;
    errors++;
    report_and_stop;
  end
  initial begin
    for (i = 0; i < 10; i++) begin
      do_reset;
      wr(1'h0, 4'h1, 32'h13);
      {sset, sval} = {1'h1, rows[i].t};
      tick(1);
      sset = 1'h0;
      enter(7'h01 << (rows[i].k - 3'h1), {16'h0, rows[i].pc});
      chk(ln, {16'h0, rows[i].ln});
      chk(bk, rows[i].bk);
      chk(kd, rows[i].k);
      chk(fbank, rows[i].k == 3'h2);
      chk(busy, 1'h0);
      chk(cur[7:0], {1'h1, rows[i].k == 3'h2, 1'h0, rows[i].md});
      chk(sav, {26'h0, rows[i].t, 5'h13});
      fret = 1'h1;
      tick(1);
      fret = 1'h0;
      tick(1);
      chk(cur[7:0], {2'h0, rows[i].t, 5'h13});
      chk(ind, rows[i].t);
    end
    do_reset;
    enter(7'h06, 32'h0);
    chk(got, 1'h0);
    wr(1'h0, 4'h1, 32'h53);
    enter(7'h06, 32'h0);
    chk(kd, 3'h3);
    do_reset;
    wr(1'h0, 4'h1, 32'h13);
    enter(7'h43, 32'h800);
    chk(kd, 3'h1);
    chk(ln, 32'h808);
    do_reset;
    sat = 1'h1;
    tick(1);
    sat = 1'h0;
    tick(3);
    chk(cur[27], 1'h1);
    chk(cond, 4'h0);
    wr(1'h1, 4'hf, 32'h1234_5678);
    chk(sav, 32'h1234_5678);
    wr(1'h0, 4'h6, 32'h00ab_cd00);
    chk(cur, 32'h08ab_cdd3);
    wr(1'h0, 4'h9, 32'h0000_0010);
    chk(cur, 32'h00ab_cd10);
    chk(rbank, 3'h7);
    wr(1'h0, 4'h1, 32'h0000_00d3);
    chk(cur[7:0], 8'h10);
    do_reset;
    wr(1'h0, 4'h1, 32'h0000_0015);
    chk(mvalid, 1'h0);
    chk(rbank, 3'h7);
    report_and_stop;
  end
endmodule
